// ### rtl/ris_pkg.sv
/*
 Shared constants, types and decode functions for the reference input
 selection and activity monitor.
 Assumes a single clock domain. The clock is taken to be the divided VCXO-PLL
 output that times the hold-off prescaler.
*/
package ris_pkg;

   localparam int NUM_INPUTS = 4;
   localparam int ADDR_W     = 4;
   localparam int DATA_W     = 8;
   localparam int SEL_W      = 2;
   localparam int VAL_W      = 9;
   localparam int HDIV_W     = 18;

   // Register offsets
   localparam logic [3:0] REG_MODE    = 4'h0;
   localparam logic [3:0] REG_HOLDOFF = 4'h1;
   localparam logic [3:0] REG_CTRL    = 4'h2;
   localparam logic [3:0] REG_PRIO    = 4'h3;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam logic [3:0] REG_IRQ     = 4'h5;
   localparam logic [3:0] REG_MASK    = 4'h6;

   // Values after reset
   localparam logic [7:0] MODE_RST    = 8'h00;
   localparam logic [7:0] HOLDOFF_RST = 8'h80;
   localparam logic [7:0] CTRL_RST    = 8'h0a;
   localparam logic [7:0] PRIO_RST    = 8'h1b;
   localparam logic [7:0] MASK_RST    = 8'h00;

   // Interrupt bit positions; bits 3:0 are per-input loss events
   localparam int IRQ_FAILOVER = 4;
   localparam int IRQ_LOCKLOSS = 5;
   localparam int IRQ_W        = 6;

   // Hold-off prescaler ratios, in clock cycles
   localparam int HOLD_DIV15 = 32768;
   localparam int HOLD_DIV16 = 65536;
   localparam int HOLD_DIV17 = 131072;

   // Cycles without an input edge that count as one missing period
   localparam int MISS_LIMIT_DEF = 64;

   typedef enum logic [1:0] {
      MODE_MANUAL,
      MODE_AUTO,
      MODE_HOLDOFF,
      MODE_AUTO_HOLD
   } ris_mode_t;

   typedef struct packed {
      logic [1:0]            selection_mode_field;
      logic [SEL_W-1:0]      manual_select;
      logic                  mask_ref_loss;
      logic                  validation_prescale_by4;
      logic [7:0]            holdoff_period;
      logic [1:0]            holdoff_prescale;
      logic [1:0]            validation_count;
      logic [NUM_INPUTS-1:0] input_power_down;
      logic [7:0]            input_priority;
   } ris_cfg_t;

   // Consecutive valid periods needed to re-validate an input
   function automatic logic [VAL_W-1:0] ris_val_periods(input logic [1:0] code,
                                                        input logic by4);
      logic [VAL_W-1:0] base;
      case (code)
         2'h0:    base = 9'h002;
         2'h1:    base = 9'h010;
         2'h2:    base = 9'h020;
         default: base = 9'h040;
      endcase
      ris_val_periods = by4 ? (base << 2) : base;
   endfunction : ris_val_periods

   // Validation count loaded at reset, from the reset count code and prescale
   localparam logic [VAL_W-1:0] VAL_RST = ris_val_periods(CTRL_RST[3:2], MODE_RST[5]);

endpackage : ris_pkg

// ### rtl/ris_input_mon.sv
/*
 Activity monitor and re-validation counter for one reference input.
 Assumes the reference input is already synchronous to clk and is much slower
 than clk, so each high phase is seen by at least one edge of clk.
*/
`timescale 1ns/100ps
`default_nettype none

module ris_input_mon
   import ris_pkg::*;
#(
   parameter int MISS_LIMIT = MISS_LIMIT_DEF
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Reference input and its controls
   input  wire logic             ref_in,
   input  wire logic             power_down,
   input  wire logic [VAL_W-1:0] val_load,
   // Status
   output logic                  signal_loss_flag,
   output logic                  loss_event
);

   localparam int GAP_W = $clog2(MISS_LIMIT + 1);
   localparam logic [GAP_W-1:0] GAP_MAX = GAP_W'(MISS_LIMIT - 1);

   logic             ref_prev;
   logic [GAP_W-1:0] gap_cnt;
   logic [VAL_W-1:0] val_cnt;

   wire edge_seen = ref_in & ~ref_prev;
   wire missing   = ~edge_seen & (gap_cnt == GAP_MAX);
   wire goes_lost = ~signal_loss_flag & (missing | power_down);
   wire revalid   = signal_loss_flag & ~power_down & edge_seen & (val_cnt <= 9'h001);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ref_prev <= 1'b0;
         gap_cnt  <= '0;
      end else begin
         ref_prev <= ref_in;
         // Saturate so a dead input keeps reporting a missing period
         if (edge_seen || power_down)
            gap_cnt <= '0;
         else if (gap_cnt != GAP_MAX)
            gap_cnt <= gap_cnt + 1'b1;
      end
   end

   // Starts flagged as lost so that every input proves itself after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         signal_loss_flag <= 1'b1;
         loss_event       <= 1'b0;
         val_cnt          <= VAL_RST;
      end else begin
         loss_event <= goes_lost;
         if (goes_lost) begin
            signal_loss_flag <= 1'b1;
            val_cnt          <= val_load;
         end else if (signal_loss_flag) begin
            if (power_down || missing)
               val_cnt <= val_load;
            else if (revalid) begin
               signal_loss_flag <= 1'b0;
               val_cnt          <= '0;
            end else if (edge_seen)
               val_cnt <= val_cnt - 1'b1;
         end
      end
   end

endmodule : ris_input_mon

`default_nettype wire

// ### rtl/ris_top.sv
/*
 Reference input selection and activity monitor for the first-stage PLL:
 manual and priority-based choice of the reference, short-term hold-off
 failover, per-input re-validation, power-down and loss-of-reference masking.
 Assumes clk is the VCXO-derived clock, reference inputs and the PLL lock
 level are synchronous to it, and a register master with single-cycle strobes.
*/
// Notes on behaviour
// - Manual mode routes selected input to PLL
// - Automatic modes ignore the manual select field
// - Hold-off counts down after loss, zero triggers failover
// - Hold-off counter reloads after each zero
// - Hold-off decrements once per prescaled tick
// - Hold-off prescaler divides by 2^15, 2^16, 2^17
// - Loss loads validation count, edges decrement it
// - Missing edge restores validation count
// - Completed validation clears the loss flag
// - Validation needs 2, 16, 32 or 64 periods
// - Divide-by-4 gives 8, 64, 128 or 256 periods
// - Per-input power-down bit disables that input
// - Mask bit drops reference loss from lock-loss indications
// - Mask bit also keeps reference loss off lock pin
// - Mode field encodes manual, auto, hold-off, auto-holdover
// - Priorities 00 lowest, ties favour lower input index
`timescale 1ns/100ps
`default_nettype none

module ris_top
   import ris_pkg::*;
#(
   parameter int NIN        = NUM_INPUTS,
   parameter int MISS_LIMIT = MISS_LIMIT_DEF,
   parameter int DIV15      = HOLD_DIV15,
   parameter int DIV16      = HOLD_DIV16,
   parameter int DIV17      = HOLD_DIV17
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // Reference inputs and PLL status
   input  wire logic [NIN-1:0]    ref_in,
   input  wire logic              pll1_locked,
   // To the reference mux and the pins
   output logic      [SEL_W-1:0]  ref_sel,
   output logic      [NIN-1:0]    ref_enable,
   output logic      [NIN-1:0]    signal_loss_flag,
   output logic                   pll1_lock_loss_live,
   output logic                   pll1_lock_loss_sticky,
   output logic                   lock_detect,
   output logic                   irq
);

   typedef enum {HO_IDLE, HO_COUNT} ris_ho_state_t;

   ris_cfg_t          cfg;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_mask;
   logic [SEL_W-1:0]  act_sel;
   logic              failover_taken;
   logic [SEL_W-1:0]  failover_sel;
   ris_ho_state_t     ho_state;
   logic [7:0]        ho_cnt;
   logic [HDIV_W-1:0] pre_cnt;
   logic [NIN-1:0]    loss;
   logic [NIN-1:0]    loss_event;

   // Best usable input: highest priority, lowest index on a tie
   function automatic logic [SEL_W:0] best_input(input logic [NIN-1:0] bad,
                                                 input logic [7:0] prio,
                                                 input logic [SEL_W-1:0] skip,
                                                 input logic use_skip);
      logic             found;
      logic [SEL_W-1:0] idx;
      logic [1:0]       bp;
      found = 1'b0;
      idx   = '0;
      bp    = '0;
      for (int i = 0; i < NIN; i++) begin
         if (!bad[i] && !(use_skip && skip == SEL_W'(i)) &&
             (!found || prio[2*i +: 2] > bp)) begin
            found = 1'b1;
            idx   = SEL_W'(i);
            bp    = prio[2*i +: 2];
         end
      end
      best_input = {found, idx};
   endfunction : best_input

   // Register decode
   wire wr_mode    = reg_wr && reg_addr == REG_MODE;
   wire wr_holdoff = reg_wr && reg_addr == REG_HOLDOFF;
   wire wr_ctrl    = reg_wr && reg_addr == REG_CTRL;
   wire wr_prio    = reg_wr && reg_addr == REG_PRIO;
   wire wr_mask    = reg_wr && reg_addr == REG_MASK;
   wire rd_irq     = reg_rd && reg_addr == REG_IRQ;

   wire ris_mode_t   mode      = ris_mode_t'(cfg.selection_mode_field);
   wire              auto_mode = cfg.selection_mode_field[0];
   wire [VAL_W-1:0]  val_load  = ris_val_periods(cfg.validation_count,
                                                 cfg.validation_prescale_by4);

   // Per-input monitors
   genvar g;
   generate
      for (g = 0; g < NIN; g++) begin : g_mon
         ris_input_mon #(
            .MISS_LIMIT (MISS_LIMIT)
         ) u_mon (
            .clk              (clk),
            .resetn           (resetn),
            .ref_in           (ref_in[g]),
            .power_down       (cfg.input_power_down[g]),
            .val_load         (val_load),
            .signal_loss_flag (loss[g]),
            .loss_event       (loss_event[g])
         );
      end
   endgenerate

   wire [NIN-1:0] unusable = loss | cfg.input_power_down;
   wire           cur_bad  = unusable[act_sel];

   // Automatic choice keeps the current input while it is good (non-revertive)
   wire [SEL_W:0] auto_pick = best_input(unusable, cfg.input_priority, act_sel, 1'b0);
   wire [SEL_W:0] fo_pick   = best_input(unusable, cfg.input_priority, act_sel, 1'b1);

   // Hold-off prescaler and counter
   wire [HDIV_W-1:0] div_sel =
      (cfg.holdoff_prescale == 2'h0) ? HDIV_W'(DIV15 - 1) :
      (cfg.holdoff_prescale == 2'h1) ? HDIV_W'(DIV16 - 1) :
                                       HDIV_W'(DIV17 - 1);
   wire ho_tick   = ho_state == HO_COUNT && pre_cnt >= div_sel;
   wire ho_zero   = ho_tick && ho_cnt <= 8'h01;
   wire ho_start  = mode == MODE_HOLDOFF && loss_event[act_sel];
   wire ho_cancel = mode != MODE_HOLDOFF || !loss[act_sel];
   wire failover  = ho_zero && fo_pick[SEL_W];

   ris_ho_state_t next_ho_state;
   always_comb begin
      next_ho_state = ho_state;
      case (ho_state)
         HO_IDLE:  if (ho_start) next_ho_state = HO_COUNT;
         HO_COUNT: if (ho_cancel && !ho_zero) next_ho_state = HO_IDLE;
         default:  next_ho_state = HO_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ho_state <= HO_IDLE;
         ho_cnt   <= HOLDOFF_RST;
         pre_cnt  <= '0;
      end else begin
         ho_state <= next_ho_state;
         if (ho_state != HO_COUNT || ho_tick)
            pre_cnt <= '0;
         else
            pre_cnt <= pre_cnt + 1'b1;
         if (ho_state != HO_COUNT || ho_zero)
            ho_cnt <= cfg.holdoff_period;
         else if (ho_tick)
            ho_cnt <= ho_cnt - 1'b1;
      end
   end

   // Failover in hold-off mode overrides the manual select until it is rewritten
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         failover_taken <= 1'b0;
         failover_sel   <= '0;
      end else if (failover) begin
         failover_taken <= 1'b1;
         failover_sel   <= fo_pick[SEL_W-1:0];
      end else if (wr_mode || mode != MODE_HOLDOFF) begin
         failover_taken <= 1'b0;
      end
   end

   // Reference selection
   logic [SEL_W-1:0] next_act_sel;
   always_comb begin
      next_act_sel = act_sel;
      case (mode)
         MODE_MANUAL:
            next_act_sel = cfg.manual_select;
         MODE_HOLDOFF:
            if (failover)
               next_act_sel = fo_pick[SEL_W-1:0];
            else
               next_act_sel = failover_taken ? failover_sel : cfg.manual_select;
         MODE_AUTO, MODE_AUTO_HOLD:
            if (cur_bad && auto_pick[SEL_W])
               next_act_sel = auto_pick[SEL_W-1:0];
         default:
            next_act_sel = cfg.manual_select;
      endcase
   end

   // Lock indications; the mask removes reference inactivity from both
   wire ref_lost       = loss[act_sel] && !cfg.mask_ref_loss;
   wire next_live_loss = !pll1_locked || ref_lost;
   wire holdover       = auto_mode && cur_bad && !auto_pick[SEL_W];

   // Sticky events; a set in the same cycle as the clearing read wins
   wire [IRQ_W-1:0] irq_set = {next_live_loss, failover, loss_event};
   wire [IRQ_W-1:0] next_irq_status = (rd_irq ? '0 : irq_status) | irq_set;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg        <= {MODE_RST[1:0], MODE_RST[3:2], MODE_RST[4], MODE_RST[5],
                        HOLDOFF_RST, CTRL_RST[1:0], CTRL_RST[3:2],
                        CTRL_RST[7:4], PRIO_RST};
         irq_mask   <= MASK_RST[IRQ_W-1:0];
      end else begin
         if (wr_mode) begin
            cfg.selection_mode_field    <= reg_wdata[1:0];
            cfg.manual_select           <= reg_wdata[3:2];
            cfg.mask_ref_loss           <= reg_wdata[4];
            cfg.validation_prescale_by4 <= reg_wdata[5];
         end
         if (wr_holdoff)
            cfg.holdoff_period <= reg_wdata;
         if (wr_ctrl) begin
            cfg.holdoff_prescale <= reg_wdata[1:0];
            cfg.validation_count <= reg_wdata[3:2];
            cfg.input_power_down <= reg_wdata[7:4];
         end
         if (wr_prio)
            cfg.input_priority <= reg_wdata;
         if (wr_mask)
            irq_mask <= reg_wdata[IRQ_W-1:0];
      end
   end

   // Read mux; unmapped offsets read zero
   wire [DATA_W-1:0] status_word = {holdover, next_live_loss, act_sel, loss};
   wire [DATA_W-1:0] rd_word =
      (reg_addr == REG_MODE)    ? {2'h0, cfg.validation_prescale_by4, cfg.mask_ref_loss,
                                   cfg.manual_select, cfg.selection_mode_field} :
      (reg_addr == REG_HOLDOFF) ? cfg.holdoff_period :
      (reg_addr == REG_CTRL)    ? {cfg.input_power_down, cfg.validation_count,
                                   cfg.holdoff_prescale} :
      (reg_addr == REG_PRIO)    ? cfg.input_priority :
      (reg_addr == REG_STATUS)  ? status_word :
      (reg_addr == REG_IRQ)     ? {2'h0, irq_status} :
      (reg_addr == REG_MASK)    ? {2'h0, irq_mask} :
                                  8'h00;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata             <= '0;
         irq_status            <= '0;
         act_sel               <= '0;
         ref_sel               <= '0;
         ref_enable            <= '0;
         signal_loss_flag      <= '1;
         pll1_lock_loss_live   <= 1'b1;
         pll1_lock_loss_sticky <= 1'b0;
         lock_detect           <= 1'b0;
         irq                   <= 1'b0;
      end else begin
         reg_rdata             <= reg_rd ? rd_word : 8'h00;
         irq_status            <= next_irq_status;
         act_sel               <= next_act_sel;
         ref_sel               <= next_act_sel;
         ref_enable            <= ~cfg.input_power_down;
         signal_loss_flag      <= loss;
         pll1_lock_loss_live   <= next_live_loss;
         pll1_lock_loss_sticky <= next_irq_status[IRQ_LOCKLOSS];
         lock_detect           <= !next_live_loss;
         irq                   <= |(next_irq_status & irq_mask);
      end
   end

endmodule : ris_top

`default_nettype wire

// ### tb/ris_top_checker.sv
/*
 Port-level checks for the reference selection block.
 Assumes it is bound to ris_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none

module ris_top_checker
   import ris_pkg::*;
#(
   parameter int NIN        = NUM_INPUTS,
   parameter int MISS_LIMIT = MISS_LIMIT_DEF
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [DATA_W-1:0] reg_rdata,
   // Inputs and status
   input  wire logic [NIN-1:0]    ref_in,
   input  wire logic              pll1_locked,
   input  wire logic [SEL_W-1:0]  ref_sel,
   input  wire logic [NIN-1:0]    ref_enable,
   input  wire logic [NIN-1:0]    signal_loss_flag,
   input  wire logic              pll1_lock_loss_live,
   input  wire logic              pll1_lock_loss_sticky,
   input  wire logic              lock_detect,
   input  wire logic              irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   wire logic  rd_irq = reg_rd && reg_addr == REG_IRQ;
   logic [7:0] quiet;
   logic       prev0;

   // Saturating count of cycles since input 0 last rose
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         quiet <= 8'h00;
         prev0 <= 1'b0;
      end else begin
         prev0 <= ref_in[0];
         quiet <= (ref_in[0] && !prev0) ? 8'h00 : quiet + 8'(quiet != 8'hff);
      end
   end

   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read slot");
   AST_ENABLE_PD: assert property (
      reg_wr && reg_addr == REG_CTRL |=> ##1 ref_enable == ~$past(reg_wdata[7:4], 2))
      else $error("input enables do not follow power-down bits");
   AST_LOCK_LIVE: assert property (!pll1_locked |=> pll1_lock_loss_live)
      else $error("live lock loss missing while unlocked");
   AST_LOCK_PIN: assert property (lock_detect == !pll1_lock_loss_live)
      else $error("lock pin disagrees with live lock loss");
   AST_STICKY_HOLD: assert property (
      pll1_lock_loss_sticky && !rd_irq && !$past(rd_irq) && !$past(rd_irq, 2)
      |=> pll1_lock_loss_sticky) else $error("sticky lock loss dropped without a read");
   AST_MANUAL_SEL: assert property (
      reg_wr && reg_addr == REG_MODE && reg_wdata[1:0] == 2'h0
      |=> ##1 ref_sel == $past(reg_wdata[3:2], 2)) else $error("manual select not routed");
   AST_LOSS_TIMEOUT: assert property (quiet >= MISS_LIMIT + 4 |-> signal_loss_flag[0])
      else $error("silent input not flagged as lost");
   AST_REVAL_EDGE: assert property ($fell(signal_loss_flag[0]) |-> quiet < 8'h03)
      else $error("loss flag cleared without a fresh edge");

   CV_SWITCH: cover property ($changed(ref_sel));
   CV_REVAL: cover property ($fell(signal_loss_flag[0]));
   CV_IRQ: cover property (irq && pll1_locked);
endmodule : ris_top_checker
`default_nettype wire

// ### tb/ris_ref_src.sv
/*
 Model of the four redundant reference clock sources.
 Assumes clk is the block clock; a stopped source stands low.
*/
`timescale 1ns/100ps
`default_nettype none

module ris_ref_src
   import ris_pkg::*;
#(
   parameter int HALF = 2
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Controls and clocks
   input  wire logic [NUM_INPUTS-1:0] run,
   input  wire logic [NUM_INPUTS-1:0] slow,
   output logic      [NUM_INPUTS-1:0] ref_clk
);
   int cnt [NUM_INPUTS];

   // A slow source stays one cycle longer in each phase, still inside the miss limit
   always @(posedge clk or negedge resetn) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (!resetn || !run[i]) begin
            ref_clk[i] <= 1'b0;
            cnt[i]     <= 0;
         end else if (cnt[i] >= HALF - 1 + int'(slow[i])) begin
            ref_clk[i] <= ~ref_clk[i];
            cnt[i]     <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end
endmodule : ris_ref_src
`default_nettype wire

// ### tb/ris_top_bench.sv
/*
 Self-checking bench for the reference selection block.
 Assumes the checker and the clock source model are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module ris_top_bench
   import ris_pkg::*;
   ;
   logic [3:0] reg_addr, ref_in, run, slow, ref_enable, loss;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic [1:0] ref_sel;
   logic       clk, resetn, reg_wr, reg_rd, pll1_locked, live, sticky, lock_det, irq;
   logic       prev3 = 1'b0;
   int         err_total, n_tests, seed, base, n, p, pr, d, cur;
   int         ecnt = 0;
   int         rst_tab [8] = '{1:8'h80, 2:8'h0a, 3:8'h1b, default:8'h00};
   int         vtab [8] = '{2, 16, 32, 64, 8, 64, 128, 256};

   ris_top #(.MISS_LIMIT(8), .DIV15(8), .DIV16(16), .DIV17(32)) uut (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
      .pll1_locked(pll1_locked), .ref_sel(ref_sel), .ref_enable(ref_enable),
      .signal_loss_flag(loss), .pll1_lock_loss_live(live),
      .pll1_lock_loss_sticky(sticky), .lock_detect(lock_det), .irq(irq));
   ris_ref_src src (.clk(clk), .resetn(resetn), .run(run), .slow(slow), .ref_clk(ref_in));

   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      prev3 <= ref_in[3];
      if (ref_in[3] && !prev3) ecnt <= ecnt + 1;
   end

   // Highest priority among the other inputs; ties go to the lower index
   function automatic int best(input int pv, input int skip);
      int b = -1;
      int bp = -1;
      for (int i = 0; i < 4; i++)
         if (i != skip && ((pv >> (2 * i)) & 3) > bp) begin
            b = i;
            bp = (pv >> (2 * i)) & 3;
         end
      return b;
   endfunction : best

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task automatic wt(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : wt

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict;
      $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pll1_locked = 1'b1;
      run = 4'h0;
      seed = 25;
      slow = 4'($random(seed));
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      run    <= 4'hf;
      for (int a = 0; a < 8; a++) begin
         if (a != 4 && a != 5) begin
            rd(4'(a), rv);
            chk(rv, rst_tab[a]);
         end
      end
      chk({ref_sel, ref_enable}, 6'h0f);
      $display("reset test done");
      // Unused input 3 is powered down while manual mode has no use for it
      for (int k = 0; k < 8; k++) begin
         n = vtab[k];
         wr(REG_MODE, {2'h0, 1'(k / 4), 5'h00});
         wr(REG_CTRL, {4'h8, 2'(k), 2'h2});
         wt(4);
         chk({ref_enable[3], loss[3]}, 2'b01);
         @(posedge clk);
         run[3] <= 1'b0;
         wr(REG_CTRL, {4'h0, 2'(k), 2'h2});
         wt(4);
         @(posedge clk);
         run[3] <= 1'b1;
         base = ecnt;
         for (int i = 0; i < 4000 && ecnt - base < n / 2; i++) @(posedge clk);
         run[3] <= 1'b0;
         repeat (20) @(posedge clk);
         run[3] <= 1'b1;
         base = ecnt;
         for (int i = 0; i < 4000 && loss[3]; i++) @(posedge clk);
         wt(1);
         chk(ecnt - base, n);
      end
      $display("validation test done");
      wr(REG_CTRL, 8'h02);
      for (int s = 0; s < 4; s++) begin
         wr(REG_MODE, {4'h0, 2'(s), 2'h0});
         wt(3);
         chk(ref_sel, s);
      end
      pr = $random(seed) & 8'hff;
      wr(REG_PRIO, 8'(pr));
      wr(REG_MODE, {4'h0, 2'($random(seed)), 2'h1});
      wt(3);
      cur = ref_sel;
      wr(REG_MODE, {4'h0, 2'($random(seed)), 2'h3});
      wt(3);
      chk(ref_sel, cur);
      @(posedge clk);
      run[cur] <= 1'b0;
      wt(40);
      chk(ref_sel, best(pr, cur));
      @(posedge clk);
      run[cur] <= 1'b1;
      wt(60);
      $display("selection test done");
      for (int c = 0; c < 4; c++) begin
         d = (c == 0) ? 8 : (c == 1) ? 16 : 32;
         p = 2 + {$random(seed)} % 3;
         wr(REG_HOLDOFF, 8'(p));
         wr(REG_CTRL, {6'h00, 2'(c)});
         wr(REG_MODE, 8'h02);
         rd(REG_IRQ, rv);
         @(posedge clk);
         run[0] <= 1'b0;
         for (int i = 0; i < 40 && !loss[0]; i++) @(posedge clk);
         for (base = 0; base < 200 && ref_sel == 2'h0; base++) @(posedge clk);
         chk((base >= (p - 1) * d && base <= p * d + 8) ? p * d : base, p * d);
         chk(ref_sel, best(pr, 0));
         rd(REG_IRQ, rv);
         chk(rv[IRQ_FAILOVER], 1'b1);
         @(posedge clk);
         run[0] <= 1'b1;
         wt(60);
      end
      $display("hold-off test done");
      wr(REG_MODE, 8'h00);
      wr(REG_MASK, 8'h20);
      rd(REG_IRQ, rv);
      wt(3);
      chk({live, lock_det, irq}, 3'b010);
      @(posedge clk);
      run[0] <= 1'b0;
      wt(30);
      chk({live, lock_det, irq, sticky}, 4'b1011);
      rd(REG_IRQ, rv);
      chk(rv & 8'h20, 8'h20);
      wr(REG_MODE, 8'h10);
      wt(3);
      chk({live, lock_det}, 2'b01);
      @(posedge clk);
      pll1_locked <= 1'b0;
      wt(3);
      chk({live, lock_det}, 2'b10);
      @(posedge clk);
      pll1_locked <= 1'b1;
      rd(REG_IRQ, rv);
      wt(3);
      chk(irq, 1'b0);
      wr(REG_MASK, 8'h00);
      $display("mask test done");
      print_verdict();
   end

   initial begin
      #1000000;
      err_total++;
      print_verdict();
   end
endmodule : ris_top_bench

bind ris_top ris_top_checker #(.NIN(NIN), .MISS_LIMIT(MISS_LIMIT)) chk_i (
   .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
   .pll1_locked(pll1_locked), .ref_sel(ref_sel), .ref_enable(ref_enable),
   .signal_loss_flag(signal_loss_flag), .pll1_lock_loss_live(pll1_lock_loss_live),
   .pll1_lock_loss_sticky(pll1_lock_loss_sticky), .lock_detect(lock_detect), .irq(irq));
`default_nettype wire
